// File: design/branch_trace_buffer.sv
// Branch trace capture: records core branch, I/O and TLB-load events for the debug host.
// Assumes core event strobes are on sys_clk; host reaches registers over a plain port.
//
// Contract
// - Store source and destination per branch; keep only the eight newest entries; continuous mode instead stops when full and keeps the first eight.
// - Normal class captures conditional, delayed conditional, relative, far and register jumps.
// - Subroutine class captures relative, far and register calls, and returns.
// - Exception class captures exception returns plus every exception and interrupt entry.
// - Continuous mode: host drains, device refills, up to four times; no real time.
// - I/O tracing with continuous mode records address and data of I/O accesses.
// - TLB-load tracing with continuous mode records the instruction's address.
// - Skip zero-displacement conditionals and the reset jump to the reset vector.
// - Completion-type exception records the address after the faulting instruction.
// - A TLB error during readout stops all further acquisition.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module branch_trace_buffer (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  trace_buffer_pkg::bus_req_t     busReq,
  output logic [31:0]                    rdData_r,
  input  trace_buffer_pkg::branch_event_t brEvt,
  input  trace_buffer_pkg::io_event_t    ioEvt,
  input  trace_buffer_pkg::tlb_event_t   tlbEvt,
  input  wire logic                      tlbError,
  output logic                           haltReq_r,
  output logic                           irq_r
);

  logic [5:0]                ctrl_r;
  logic [2:0]                rdIdx_r;
  logic [2:0]                drains_r;
  logic                      dead_r;
  logic                      readout_r;
  logic [2:0]                irqStat_r;
  logic [2:0]                irqMask_r;
  logic [2:0]                irqStat_nxt;
  logic [31:0]               rdData_nxt;

  trace_buffer_pkg::entry_t  pushEntry;
  trace_buffer_pkg::entry_t  rdEntry;
  logic [3:0]                storeCount;

  // Register decode
  wire wrCtrl    = busReq.wr && busReq.addr == trace_buffer_pkg::OFS_CTRL;
  wire wrIrqStat = busReq.wr && busReq.addr == trace_buffer_pkg::OFS_IRQ_STAT;
  wire wrIrqMask = busReq.wr && busReq.addr == trace_buffer_pkg::OFS_IRQ_MASK;
  wire wrRdIdx   = busReq.wr && busReq.addr == trace_buffer_pkg::OFS_RD_INDEX;
  wire drainWr   = busReq.wr && busReq.addr == trace_buffer_pkg::OFS_DRAIN;
  wire startWr   = wrCtrl && busReq.wdata[trace_buffer_pkg::CTRL_START];
  wire rdEntryReg = busReq.rd && (busReq.addr == trace_buffer_pkg::OFS_ENTRY_SRC
                                  || busReq.addr == trace_buffer_pkg::OFS_ENTRY_DST
                                  || busReq.addr == trace_buffer_pkg::OFS_ENTRY_TAG);

  wire enNormal = ctrl_r[trace_buffer_pkg::CTRL_EN_NORMAL];
  wire enSub    = ctrl_r[trace_buffer_pkg::CTRL_EN_SUB];
  wire enExc    = ctrl_r[trace_buffer_pkg::CTRL_EN_EXC];
  wire contMode = ctrl_r[trace_buffer_pkg::CTRL_CONT];
  wire ioTrace  = ctrl_r[trace_buffer_pkg::CTRL_IO_TRACE];
  wire tlbTrace = ctrl_r[trace_buffer_pkg::CTRL_TLB_TRACE];

  // Branch classification
  wire isCond = brEvt.kind inside {trace_buffer_pkg::BRANCH_IF_FALSE, trace_buffer_pkg::BRANCH_IF_TRUE};
  wire isNormal = isCond || brEvt.kind inside {trace_buffer_pkg::BRANCH_IF_FALSE_DELAYED,
    trace_buffer_pkg::BRANCH_IF_TRUE_DELAYED, trace_buffer_pkg::RELATIVE_JUMP,
    trace_buffer_pkg::FAR_RELATIVE_JUMP, trace_buffer_pkg::REGISTER_JUMP};
  wire isSub = brEvt.kind inside {trace_buffer_pkg::RELATIVE_CALL, trace_buffer_pkg::FAR_RELATIVE_CALL,
    trace_buffer_pkg::REGISTER_CALL, trace_buffer_pkg::SUB_RETURN};
  wire isExcEntry = brEvt.kind inside {trace_buffer_pkg::EXCEPTION_ENTRY, trace_buffer_pkg::INTERRUPT_ENTRY};
  wire isExc = isExcEntry || brEvt.kind == trace_buffer_pkg::EXCEPTION_RETURN;
  wire classOn = (isNormal && enNormal) || (isSub && enSub) || (isExc && enExc);
  wire skipBranch = (isCond && brEvt.dispZero)
                    || (brEvt.byReset && brEvt.dstAddr == trace_buffer_pkg::RESET_VECTOR);

  // Acquisition gating: continuous mode stops at full and after the last refill
  wire storeFull = storeCount == trace_buffer_pkg::DEPTH_COUNT;
  wire acqDone   = drains_r == trace_buffer_pkg::MAX_DRAINS;
  wire canStore  = !dead_r && !(contMode && (storeFull || acqDone));

  wire brTake  = canStore && brEvt.valid && classOn && !skipBranch;
  wire ioTake  = canStore && ioEvt.valid && contMode && ioTrace && !brTake;
  wire tlbTake = canStore && tlbEvt.valid && contMode && tlbTrace && !brTake && !ioTake;
  wire push    = brTake || ioTake || tlbTake;
  wire clearStore = startWr || (drainWr && contMode && !acqDone);

  // Completion-type exceptions report the following instruction as source
  wire useNext = isExcEntry && brEvt.completion;
  wire [31:0] brSrc = useNext ? brEvt.nextAddr : brEvt.srcAddr;

  always_comb
  begin
    pushEntry = '0;
    if (brTake)
    begin
      pushEntry.tag = trace_buffer_pkg::TAG_BRANCH;
      pushEntry.src = brSrc;
      pushEntry.dst = brEvt.dstAddr;
    end
    else if (ioTake)
    begin
      pushEntry.tag = trace_buffer_pkg::TAG_IO;
      pushEntry.src = ioEvt.addr;
      pushEntry.dst = ioEvt.data;
    end
    else if (tlbTake)
    begin
      pushEntry.tag = trace_buffer_pkg::TAG_TLB;
      pushEntry.src = tlbEvt.pcAddr;
    end
  end

  trace_entry_store u_store (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clear     (clearStore),
    .push      (push),
    .pushEntry (pushEntry),
    .rdIdx     (rdIdx_r),
    .rdEntry   (rdEntry),
    .count     (storeCount)
  );

  // Read mux
  wire [31:0] statusWord = {21'h0, drains_r, acqDone, haltReq_r, dead_r, storeFull, storeCount};
  always_comb
  begin
    rdData_nxt = 32'h0;
    if (busReq.rd)
    begin
      case (busReq.addr)
        trace_buffer_pkg::OFS_CTRL:      rdData_nxt = {26'h0, ctrl_r};
        trace_buffer_pkg::OFS_STATUS:    rdData_nxt = statusWord;
        trace_buffer_pkg::OFS_IRQ_STAT:  rdData_nxt = {29'h0, irqStat_r};
        trace_buffer_pkg::OFS_IRQ_MASK:  rdData_nxt = {29'h0, irqMask_r};
        trace_buffer_pkg::OFS_RD_INDEX:  rdData_nxt = {29'h0, rdIdx_r};
        trace_buffer_pkg::OFS_ENTRY_SRC: rdData_nxt = rdEntry.src;
        trace_buffer_pkg::OFS_ENTRY_DST: rdData_nxt = rdEntry.dst;
        trace_buffer_pkg::OFS_ENTRY_TAG: rdData_nxt = {30'h0, rdEntry.tag};
        default:                         rdData_nxt = 32'h0;
      endcase
    end
  end

  // Events win over a write-one-to-clear in the same cycle
  wire       fullEvt = contMode && !storeFull && push && storeCount == 4'h7;
  wire       deadEvt = !dead_r && tlbError && readout_r;
  wire       doneEvt = drainWr && contMode && drains_r == 3'h3;
  wire [2:0] irqEvt  = {doneEvt, deadEvt, fullEvt};
  assign irqStat_nxt = (irqStat_r & ~(wrIrqStat ? busReq.wdata[2:0] : 3'h0)) | irqEvt;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_r    <= trace_buffer_pkg::CTRL_RESET;
      irqStat_r <= trace_buffer_pkg::IRQ_RESET;
      irqMask_r <= trace_buffer_pkg::IRQ_RESET;
      rdIdx_r   <= 3'h0;
      rdData_r  <= 32'h0;
      irq_r     <= 1'b0;
    end
    else
    begin
      ctrl_r    <= wrCtrl ? busReq.wdata[5:0] : ctrl_r;
      irqMask_r <= wrIrqMask ? busReq.wdata[2:0] : irqMask_r;
      rdIdx_r   <= wrRdIdx ? busReq.wdata[2:0] : rdIdx_r;
      irqStat_r <= irqStat_nxt;
      rdData_r  <= rdData_nxt;
      irq_r     <= |(irqStat_nxt & irqMask_r);
    end
  end

  // Drain count, readout window and the sticky stop after a TLB error
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      drains_r  <= 3'h0;
      dead_r    <= 1'b0;
      readout_r <= 1'b0;
      haltReq_r <= 1'b0;
    end
    else
    begin
      if (startWr)
        drains_r <= 3'h0;
      else if (drainWr && contMode && !acqDone)
        drains_r <= drains_r + 3'h1;
      if (deadEvt)
        dead_r <= 1'b1;
      readout_r <= rdEntryReg || (readout_r && !startWr);
      // Halt request asks the host to stop the program and collect
      haltReq_r <= contMode && !dead_r && !clearStore && (storeFull || fullEvt) && !acqDone;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_zero_disp_skip: assert property (brEvt.valid && isCond && brEvt.dispZero |-> !push)
    else $error("zero displacement branch recorded");
  a_reset_jump_skip: assert property (brEvt.valid && brEvt.byReset
      && brEvt.dstAddr == trace_buffer_pkg::RESET_VECTOR |-> !brTake)
    else $error("reset vector jump recorded");
  a_class_gate: assert property (brTake |-> classOn)
    else $error("branch recorded with class disabled");
  a_normal_capture: assert property (brEvt.valid && isNormal && enNormal && !skipBranch && canStore
      |-> push && pushEntry.dst == brEvt.dstAddr)
    else $error("enabled normal branch not recorded");
  a_sub_capture: assert property (brEvt.valid && isSub && enSub && canStore |-> brTake)
    else $error("enabled subroutine branch not recorded");
  a_exc_capture: assert property (brEvt.valid && isExc && enExc && canStore |-> brTake)
    else $error("enabled exception branch not recorded");
  a_depth_grows: assert property (push && !clearStore && !storeFull
      |=> storeCount == $past(storeCount) + 4'h1)
    else $error("entry count did not advance");
  a_depth_limit: assert property (storeCount <= trace_buffer_pkg::DEPTH_COUNT)
    else $error("more than eight entries held");
  a_cont_full_halt: assert property (contMode && storeFull && !clearStore && !dead_r && !acqDone
      |-> !push ##1 haltReq_r)
    else $error("full continuous buffer not held for host");
  a_drain_bound: assert property (drains_r <= trace_buffer_pkg::MAX_DRAINS)
    else $error("more than four refills");
  a_io_needs_cont: assert property (push && pushEntry.tag == trace_buffer_pkg::TAG_IO
      |-> contMode && ioTrace && pushEntry.src == ioEvt.addr)
    else $error("I/O access recorded outside continuous I/O trace");
  a_tlb_needs_cont: assert property (push && pushEntry.tag == trace_buffer_pkg::TAG_TLB
      |-> contMode && tlbTrace && pushEntry.src == tlbEvt.pcAddr)
    else $error("TLB load recorded outside continuous TLB trace");
  a_completion_src: assert property (brTake && isExcEntry && brEvt.completion
      |-> pushEntry.src == brEvt.nextAddr)
    else $error("completion exception source not the following address");
  a_dead_sticky: assert property (dead_r |=> dead_r && !push)
    else $error("acquisition resumed after TLB error");
  a_dead_entry: assert property (tlbError && readout_r && !dead_r |=> dead_r [*3])
    else $error("TLB error during readout did not stop acquisition");

  c_cont_fill: cover property (contMode && push && storeCount == 4'h7);
  c_all_drains: cover property (doneEvt);
  c_tlb_stop: cover property (deadEvt);
  c_ring_wrap: cover property (!contMode && storeFull && push);

endmodule : branch_trace_buffer

// File: design/trace_buffer_pkg.sv
// Shared types and constants for the branch trace capture block.
// Assumes a single core clock and a synchronous active-high reset.
package trace_buffer_pkg;

  localparam int unsigned      DEPTH        = 8;
  localparam logic [3:0]       DEPTH_COUNT  = 4'h8;
  localparam logic [2:0]       MAX_DRAINS   = 3'h4;
  localparam logic [31:0]      RESET_VECTOR = 32'hA0000000;

  // Register offsets (byte addresses on the plain port)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] OFS_RD_INDEX  = 8'h10;
  localparam logic [7:0] OFS_ENTRY_SRC = 8'h14;
  localparam logic [7:0] OFS_ENTRY_DST = 8'h18;
  localparam logic [7:0] OFS_ENTRY_TAG = 8'h1C;
  localparam logic [7:0] OFS_DRAIN     = 8'h20;

  // Control field positions
  localparam int unsigned CTRL_EN_NORMAL = 0;
  localparam int unsigned CTRL_EN_SUB    = 1;
  localparam int unsigned CTRL_EN_EXC    = 2;
  localparam int unsigned CTRL_CONT      = 3;
  localparam int unsigned CTRL_IO_TRACE  = 4;
  localparam int unsigned CTRL_TLB_TRACE = 5;
  localparam int unsigned CTRL_START     = 8;
  localparam logic [5:0]  CTRL_RESET     = 6'h00;

  // Status field positions
  localparam int unsigned STAT_COUNT_LSB = 0;
  localparam int unsigned STAT_FULL      = 4;
  localparam int unsigned STAT_DEAD      = 5;
  localparam int unsigned STAT_HALT      = 6;
  localparam int unsigned STAT_DONE      = 7;
  localparam int unsigned STAT_DRAIN_LSB = 8;

  // Interrupt status bits
  localparam int unsigned IRQ_FULL  = 0;
  localparam int unsigned IRQ_DEAD  = 1;
  localparam int unsigned IRQ_DONE  = 2;
  localparam logic [2:0]  IRQ_RESET = 3'h0;

  // Entry tags
  localparam logic [1:0] TAG_BRANCH = 2'h0;
  localparam logic [1:0] TAG_IO     = 2'h1;
  localparam logic [1:0] TAG_TLB    = 2'h2;

  typedef enum logic [3:0] {
    BRANCH_IF_FALSE,
    BRANCH_IF_TRUE,
    BRANCH_IF_FALSE_DELAYED,
    BRANCH_IF_TRUE_DELAYED,
    RELATIVE_JUMP,
    FAR_RELATIVE_JUMP,
    REGISTER_JUMP,
    RELATIVE_CALL,
    FAR_RELATIVE_CALL,
    REGISTER_CALL,
    SUB_RETURN,
    EXCEPTION_RETURN,
    EXCEPTION_ENTRY,
    INTERRUPT_ENTRY
  } branch_kind_t;

  typedef struct packed {
    logic         valid;
    branch_kind_t kind;
    logic         dispZero;
    logic         byReset;
    logic         completion;
    logic [31:0]  srcAddr;
    logic [31:0]  dstAddr;
    logic [31:0]  nextAddr;
  } branch_event_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } io_event_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pcAddr;
  } tlb_event_t;

  typedef struct packed {
    logic [1:0]  tag;
    logic [31:0] src;
    logic [31:0] dst;
  } entry_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

endpackage : trace_buffer_pkg

// File: design/trace_entry_store.sv
// Eight-entry ring of trace entries held in flip-flops.
// Assumes the caller gates pushes; a push while full drops the oldest.
`timescale 1ns/1ps
module trace_entry_store (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    clear,
  input  wire logic                    push,
  input  trace_buffer_pkg::entry_t     pushEntry,
  input  wire logic [2:0]              rdIdx,
  output trace_buffer_pkg::entry_t     rdEntry,
  output logic [3:0]                   count
);

  trace_buffer_pkg::entry_t entry_r [trace_buffer_pkg::DEPTH];
  logic [2:0]               wrPtr_r;
  logic [3:0]               count_r;
  logic [2:0]               oldest;
  logic                     full;

  assign full    = (count_r == trace_buffer_pkg::DEPTH_COUNT);
  assign oldest  = wrPtr_r - count_r[2:0];
  assign rdEntry = entry_r[3'(oldest + rdIdx)];
  assign count   = count_r;

  genvar gi;
  generate
    for (gi = 0; gi < trace_buffer_pkg::DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          entry_r[gi] <= '0;
        else if (push && !clear && wrPtr_r == 3'(gi))
          entry_r[gi] <= pushEntry;
      end
    end
  endgenerate

  // Full ring keeps its count; the oldest slot is the one overwritten
  always_ff @(posedge sys_clk)
  begin
    if (rst || clear)
    begin
      wrPtr_r <= 3'h0;
      count_r <= 4'h0;
    end
    else if (push)
    begin
      wrPtr_r <= wrPtr_r + 3'h1;
      count_r <= full ? count_r : count_r + 4'h1;
    end
  end

endmodule : trace_entry_store

// File: test/debug_host_model.sv
// Debug host stand-in: drains the trace buffer each time the device asks for collection.
// Assumes the bench gives it the register port whenever its write strobe is high.
`timescale 1ns/1ps
module debug_host_model (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  autoDrain,
  input  wire logic                  haltReq_r,
  output trace_buffer_pkg::bus_req_t hostReq
);
  logic [1:0] gap_r;

  // Cool-down keeps one drain per halt, since the halt flag falls only after the write lands
  always_ff @(posedge sys_clk)
  begin
    hostReq.rd    <= 1'b0;
    hostReq.addr  <= ~hostReq.addr;
    hostReq.wdata <= ~hostReq.wdata;
    if (rst || !autoDrain)
    begin
      hostReq.wr <= 1'b0;
      gap_r      <= 2'h0;
    end
    else if (haltReq_r && gap_r == 2'h0 && !hostReq.wr)
    begin
      hostReq.wr    <= 1'b1;
      hostReq.addr  <= trace_buffer_pkg::OFS_DRAIN;
      hostReq.wdata <= 32'h0;
      gap_r         <= 2'h3;
    end
    else
    begin
      hostReq.wr <= 1'b0;
      gap_r      <= (gap_r == 2'h0) ? 2'h0 : gap_r - 2'h1;
    end
  end
endmodule : debug_host_model

// File: test/tb_top.sv
// Self-checking bench for branch trace capture: class gating, ring, skips, continuous drain, stop.
// Assumes the design package is compiled first; the core clock runs at 10 MHz.
`timescale 1ns/1ps
module tb_top;
  logic                            sys_clk = 1'b0;
  logic                            rst = 1'b1;
  trace_buffer_pkg::bus_req_t      tbReq = '0;
  trace_buffer_pkg::bus_req_t      hostReq;
  trace_buffer_pkg::bus_req_t      busReq;
  trace_buffer_pkg::branch_event_t brEvt = '0;
  trace_buffer_pkg::io_event_t     ioEvt = '0;
  trace_buffer_pkg::tlb_event_t    tlbEvt = '0;
  logic                            tlbError = 1'b0;
  logic                            autoDrain = 1'b0;
  logic [31:0]                     rdData_r;
  logic                            haltReq_r;
  logic                            irq_r;
  logic [31:0]                     rv;
  logic [31:0]                     srcQ [10];
  logic [31:0]                     dstQ [10];
  int                              err_count = 0;
  int                              comparisons = 0;

  always #50 sys_clk = ~sys_clk;
  assign busReq = hostReq.wr ? hostReq : tbReq;

  branch_trace_buffer u_dut (.sys_clk(sys_clk), .rst(rst), .busReq(busReq), .rdData_r(rdData_r),
    .brEvt(brEvt), .ioEvt(ioEvt), .tlbEvt(tlbEvt), .tlbError(tlbError), .haltReq_r(haltReq_r), .irq_r(irq_r));
  debug_host_model u_host (.sys_clk(sys_clk), .rst(rst), .autoDrain(autoDrain), .haltReq_r(haltReq_r),
    .hostReq(hostReq));

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data are taken in the one cycle after the strobe
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge sys_clk);
    tbReq <= '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
    @(posedge sys_clk);
    tbReq <= '0;
    #1 rv = rdData_r;
  endtask : bus

  task automatic cnt(input logic [31:0] exp);
    bus(1'b0, trace_buffer_pkg::OFS_STATUS, 32'h0);
    chk(rv & 32'hF, exp);
  endtask : cnt

  task automatic br(input logic [3:0] k, input logic [31:0] s, input logic [31:0] d, input logic [2:0] f);
    @(posedge sys_clk);
    brEvt <= '{valid: 1'b1, kind: trace_buffer_pkg::branch_kind_t'(k), dispZero: f[2], byReset: f[1],
               completion: f[0], srcAddr: s, dstAddr: d, nextAddr: s + 32'h2};
    @(posedge sys_clk);
    brEvt.valid <= 1'b0;
  endtask : br

  task automatic pulse_io(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    ioEvt <= '{valid: 1'b1, addr: a, data: d};
    @(posedge sys_clk);
    ioEvt.valid <= 1'b0;
  endtask : pulse_io

  task automatic wait_low();
    for (int n = 0; n < 50 && haltReq_r !== 1'b0; n++)
      @(posedge sys_clk);
    if (haltReq_r !== 1'b0)
    begin
      err_count++;
      end_of_test();
    end
  endtask : wait_low

  function automatic logic [31:0] klass(input logic [3:0] k);
    return (k <= 4'h6) ? 32'h0 : (k <= 4'hA) ? 32'h1 : 32'h2;
  endfunction : klass

  initial
  begin
    void'($urandom(38413));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, trace_buffer_pkg::OFS_STATUS, 32'h0);
    chk(rv, 32'h0);
    bus(1'b0, 8'h3C, 32'h0);
    chk(rv, 32'h0);
    chk({30'h0, haltReq_r, irq_r}, 32'h0);
    for (int k = 0; k < 14; k++)
      for (int c = 0; c < 3; c++)
      begin
        bus(1'b1, trace_buffer_pkg::OFS_CTRL, 32'h100 | (32'h1 << c));
        br(4'(k), $urandom, $urandom, 3'h0);
        cnt((klass(4'(k)) == 32'(c)) ? 32'h1 : 32'h0);
      end
    bus(1'b1, trace_buffer_pkg::OFS_CTRL, 32'h101);
    br(4'h1, $urandom, $urandom, 3'h4);
    br(4'h6, $urandom, trace_buffer_pkg::RESET_VECTOR, 3'h2);
    cnt(32'h0);
    br(4'h0, $urandom, $urandom, 3'h0);
    cnt(32'h1);
    bus(1'b1, trace_buffer_pkg::OFS_CTRL, 32'h104);
    br(4'hC, 32'h1000, 32'h2000, 3'h1);
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_SRC, 32'h0);
    chk(rv, 32'h1002);
    // Ten branches into eight slots: the two oldest must be gone
    bus(1'b1, trace_buffer_pkg::OFS_CTRL, 32'h107);
    for (int i = 0; i < 10; i++)
    begin
      srcQ[i] = $urandom;
      dstQ[i] = $urandom;
      br(4'($urandom_range(13)), srcQ[i], dstQ[i], 3'h0);
    end
    cnt(32'h8);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, trace_buffer_pkg::OFS_RD_INDEX, 32'(i));
      bus(1'b0, trace_buffer_pkg::OFS_ENTRY_SRC, 32'h0);
      chk(rv, srcQ[i + 2]);
      bus(1'b0, trace_buffer_pkg::OFS_ENTRY_DST, 32'h0);
      chk(rv, dstQ[i + 2]);
    end
    bus(1'b1, trace_buffer_pkg::OFS_IRQ_MASK, 32'h1);
    bus(1'b1, trace_buffer_pkg::OFS_CTRL, 32'h139);
    for (int i = 0; i < 8; i++)
    begin
      srcQ[i] = $urandom;
      dstQ[i] = $urandom;
      pulse_io(srcQ[i], dstQ[i]);
    end
    cnt(32'h8);
    chk({31'h0, haltReq_r}, 32'h1);
    chk({31'h0, irq_r}, 32'h1);
    bus(1'b1, trace_buffer_pkg::OFS_RD_INDEX, 32'h3);
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_TAG, 32'h0);
    chk(rv, {30'h0, trace_buffer_pkg::TAG_IO});
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_SRC, 32'h0);
    chk(rv, srcQ[3]);
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_DST, 32'h0);
    chk(rv, dstQ[3]);
    bus(1'b1, trace_buffer_pkg::OFS_IRQ_STAT, 32'h1);
    bus(1'b0, trace_buffer_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rv, 32'h0);
    chk({31'h0, irq_r}, 32'h0);
    bus(1'b1, trace_buffer_pkg::OFS_IRQ_MASK, 32'h4);
    @(posedge sys_clk);
    autoDrain <= 1'b1;
    wait_low();
    cnt(32'h0);
    @(posedge sys_clk);
    tlbEvt <= '{valid: 1'b1, pcAddr: 32'h8C00_1234};
    @(posedge sys_clk);
    tlbEvt.valid <= 1'b0;
    bus(1'b1, trace_buffer_pkg::OFS_RD_INDEX, 32'h0);
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_TAG, 32'h0);
    chk(rv, {30'h0, trace_buffer_pkg::TAG_TLB});
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_SRC, 32'h0);
    chk(rv, 32'h8C00_1234);
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_DST, 32'h0);
    chk(rv, 32'h0);
    // More events than four buffers hold; the host drains each time it is asked
    for (int i = 0; i < 40; i++)
    begin
      br(4'($urandom_range(6)), $urandom, $urandom, 3'h0);
      repeat (3) @(posedge sys_clk);
    end
    wait_low();
    bus(1'b0, trace_buffer_pkg::OFS_STATUS, 32'h0);
    chk(rv & 32'h780, 32'h480);
    chk({31'h0, irq_r}, 32'h1);
    @(posedge sys_clk);
    autoDrain <= 1'b0;
    bus(1'b1, trace_buffer_pkg::OFS_CTRL, 32'h101);
    br(4'h4, $urandom, $urandom, 3'h0);
    bus(1'b0, trace_buffer_pkg::OFS_ENTRY_SRC, 32'h0);
    @(posedge sys_clk);
    tlbError <= 1'b1;
    @(posedge sys_clk);
    tlbError <= 1'b0;
    br(4'h4, $urandom, $urandom, 3'h0);
    bus(1'b0, trace_buffer_pkg::OFS_STATUS, 32'h0);
    chk(rv & 32'h3F, 32'h21);
    bus(1'b1, trace_buffer_pkg::OFS_CTRL, 32'h101);
    br(4'h5, $urandom, $urandom, 3'h0);
    bus(1'b0, trace_buffer_pkg::OFS_STATUS, 32'h0);
    chk(rv & 32'h3F, 32'h20);
    end_of_test();
  end

  initial
  begin
    #10000000;
    err_count++;
    end_of_test();
  end
endmodule : tb_top
